// File: core/freq_counter_pkg.sv
`default_nettype none

package freq_counter_pkg;

   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL     = 8'h00;
   localparam logic [7:0] ADDR_STATUS   = 8'h04;
   localparam logic [7:0] ADDR_LOW      = 8'h08;
   localparam logic [7:0] ADDR_HIGH     = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ZSPAN_BIT = 1;
   localparam int CTRL_ACK_BIT   = 2;
   localparam int CTRL_RES_LSB   = 4;
   localparam int IRQ_DONE_BIT   = 0;
   localparam int IRQ_OVF_BIT    = 1;
   localparam int STATUS_GATE_BIT = 0;
   localparam int STATUS_OVF_BIT  = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int          REF_DIVIDE     = 5;
   localparam int          TIMEBASE_KHZ   = 2000;
   localparam int          HOST_CLK_KHZ   = 4000;
   localparam int          GATE_LONG_US   = 200000;
   localparam int          GATE_MID_US    = 20000;
   localparam int          GATE_SHORT_US  = 2000;
   localparam int          GATE_W         = 20;
   localparam int          HIGH_W         = 16;
   localparam logic [2:0]  REF_DIV_LAST   = 3'(REF_DIVIDE - 1);
   localparam logic [3:0]  NIBBLE_MAX     = 4'hF;

   typedef enum logic [2:0] {
      RES_10HZ  = 3'b000,
      RES_100HZ = 3'b001,
      RES_1KHZ  = 3'b010,
      RES_10KHZ = 3'b011,
      RES_100KHZ= 3'b100,
      RES_1MHZ  = 3'b101
   } res_t;

   typedef struct packed {
      res_t res;
      logic ack_en;
      logic zero_span;
   } ctrl_t;

   typedef struct packed {
      logic overflow;
      logic done;
   } irq_t;

endpackage

`default_nettype wire

// File: core/if_frequency_counter.sv
// Summary of operation
// - Divide the 10 MHz reference by five into a 2 MHz timebase.
// - Zero-span mode selects the 4 MHz host bus clock as timing reference.
// - Selected clock drives channel two; its output is the gate window.
// - Resolution selectable in decade steps from 10 Hz to 1 MHz.
// - Gate lasts 200 ms at 10 Hz, 20 ms at 100 Hz, else 2 ms.
// - Gate window low for the gate time, up to one tick short; count only then.
// - Gated input clocks two cascaded divide-by-16 stages, one divide-by-256.
// - Prescaler top bit clocks channel zero, the high-order count.
// - Top bit rate equals input frequency over 256; channel zero counts that times the gate time.
// - Channel zero overflow sets its output; with acknowledge enable high it latches overflow interrupt.
// - With acknowledge enable high, gate end sets count-complete interrupt.
// - Input path sized for a nominal 5.35 MHz signal.
`timescale 1ns/10ps
`default_nettype none

module if_frequency_counter #(
   parameter int GATE_LONG_US_P  = freq_counter_pkg::GATE_LONG_US,
   parameter int GATE_MID_US_P   = freq_counter_pkg::GATE_MID_US,
   parameter int GATE_SHORT_US_P = freq_counter_pkg::GATE_SHORT_US
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // measurement inputs, sampled on aclk
   input  wire logic        ref_clock_in,
   input  wire logic        host_bus_clock,
   input  wire logic        counter_input,
   // outputs
   output logic             gate_window_out,
   output logic             timer_ch_zero_output,
   output logic             irq
);
   import freq_counter_pkg::*;

   // ----------------------------------------
   // gate lengths in timebase and host clock ticks
   // ----------------------------------------
   localparam logic [GATE_W-1:0] TB_LONG   = GATE_W'(GATE_LONG_US_P * (TIMEBASE_KHZ / 1000));
   localparam logic [GATE_W-1:0] TB_MID    = GATE_W'(GATE_MID_US_P * (TIMEBASE_KHZ / 1000));
   localparam logic [GATE_W-1:0] TB_SHORT  = GATE_W'(GATE_SHORT_US_P * (TIMEBASE_KHZ / 1000));
   localparam logic [GATE_W-1:0] HB_LONG   = GATE_W'(GATE_LONG_US_P * (HOST_CLK_KHZ / 1000));
   localparam logic [GATE_W-1:0] HB_MID    = GATE_W'(GATE_MID_US_P * (HOST_CLK_KHZ / 1000));
   localparam logic [GATE_W-1:0] HB_SHORT  = GATE_W'(GATE_SHORT_US_P * (HOST_CLK_KHZ / 1000));
   localparam logic [GATE_W-1:0] GATE_ONE  = GATE_W'(1);
   localparam logic [HIGH_W-1:0] HIGH_MAX  = '1;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      ctrl_t             ctrl;
      irq_t              irq_stat;
      irq_t              irq_mask;
      logic [2:0]        ref_div;
      logic              ref_q;
      logic              host_q;
      logic              in_q;
      logic              msb_q;
      logic              gate_active;
      logic [GATE_W-1:0] gate_cnt;
      logic [HIGH_W-1:0] high_count;
      logic              ovf_out;
      logic              gate_n;
      logic              irq_out;
   } state_t;

   state_t s;
   state_t next_s;

   logic [3:0] low_nib;
   logic [3:0] high_nib;
   logic       low_carry;
   logic       count_edge;
   logic       start;

   // ----------------------------------------
   // divide-by-256 prescaler
   // ----------------------------------------
   nibble_counter u_low_stage (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (start),
      .inc     (count_edge),
      .count   (low_nib),
      .carry   (low_carry)
   );

   nibble_counter u_high_stage (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (start),
      .inc     (low_carry),
      .count   (high_nib),
      .carry   ()
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic              wr_go;
   logic              rd_go;
   logic              ref_tick;
   logic              host_tick;
   logic              sel_tick;
   logic              gate_end;
   logic              msb_fall;
   logic [GATE_W-1:0] gate_len;
   logic [7:0]        low_count;
   irq_t              set_irq;
   irq_t              w1c;

   always_comb begin
      next_s    = s;
      low_count = {high_nib, low_nib};
      wr_go     = s_axi_awvalid && s_axi_wvalid && !s.awready && !s.bvalid;
      rd_go     = s_axi_arvalid && !s.arready && !s.rvalid;
      start     = 1'b0;
      set_irq   = '0;
      w1c       = '0;

      // ----------------------------------------
      // reference divider and clock select
      // ----------------------------------------
      // pins are sampled on aclk; an edge is a rise from the last sample
      ref_tick  = 1'b0;
      next_s.ref_q  = ref_clock_in;
      next_s.host_q = host_bus_clock;
      next_s.in_q   = counter_input;
      if (ref_clock_in && !s.ref_q) begin
         if (s.ref_div == REF_DIV_LAST) begin
            next_s.ref_div = 3'h0;
            ref_tick       = 1'b1;
         end else begin
            next_s.ref_div = s.ref_div + 3'h1;
         end
      end
      host_tick = host_bus_clock && !s.host_q;
      sel_tick  = s.ctrl.zero_span ? host_tick : ref_tick;

      // ----------------------------------------
      // register writes
      // ----------------------------------------
      // address and data are taken together; a lone valid waits for its partner
      next_s.awready = wr_go;
      next_s.wready  = wr_go;
      if (s.bvalid && s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end
      if (wr_go) begin
         next_s.bvalid = 1'b1;
         next_s.bresp  = RESP_OKAY;
         if (s_axi_awaddr == ADDR_CTRL) begin
            if (s_axi_wstrb[0]) begin
               next_s.ctrl.zero_span = s_axi_wdata[CTRL_ZSPAN_BIT];
               next_s.ctrl.ack_en    = s_axi_wdata[CTRL_ACK_BIT];
               next_s.ctrl.res       = res_t'(s_axi_wdata[CTRL_RES_LSB +: 3]);
               start                 = s_axi_wdata[CTRL_START_BIT];
            end
         end else if (s_axi_awaddr == ADDR_IRQ_STAT) begin
            if (s_axi_wstrb[0]) begin
               w1c.done     = s_axi_wdata[IRQ_DONE_BIT];
               w1c.overflow = s_axi_wdata[IRQ_OVF_BIT];
            end
         end else if (s_axi_awaddr == ADDR_IRQ_MASK) begin
            if (s_axi_wstrb[0]) begin
               next_s.irq_mask.done     = s_axi_wdata[IRQ_DONE_BIT];
               next_s.irq_mask.overflow = s_axi_wdata[IRQ_OVF_BIT];
            end
         end else if (s_axi_awaddr == ADDR_STATUS || s_axi_awaddr == ADDR_LOW
                      || s_axi_awaddr == ADDR_HIGH) begin
            next_s.bresp = RESP_OKAY;
         end else begin
            next_s.bresp = RESP_SLVERR;
         end
      end

      // ----------------------------------------
      // gate length by resolution
      // ----------------------------------------
      // taken from the value being written, so a start that also sets the
      // resolution or the reference times the gate it asks for
      case (next_s.ctrl.res)
         RES_10HZ:  gate_len = next_s.ctrl.zero_span ? HB_LONG : TB_LONG;
         RES_100HZ: gate_len = next_s.ctrl.zero_span ? HB_MID : TB_MID;
         default:   gate_len = next_s.ctrl.zero_span ? HB_SHORT : TB_SHORT;
      endcase

      // ----------------------------------------
      // gate window timer
      // ----------------------------------------
      // a start while the gate runs simply reloads it
      gate_end = 1'b0;
      if (start) begin
         next_s.gate_active = 1'b1;
         next_s.gate_cnt    = gate_len;
         next_s.high_count  = '0;
         next_s.ovf_out     = 1'b0;
      end else if (s.gate_active && sel_tick) begin
         if (s.gate_cnt == GATE_ONE) begin
            next_s.gate_active = 1'b0;
            gate_end           = 1'b1;
         end else begin
            next_s.gate_cnt = s.gate_cnt - GATE_ONE;
         end
      end
      next_s.gate_n = !next_s.gate_active;

      // ----------------------------------------
      // prescaler input
      // ----------------------------------------
      // only rising input edges inside the window reach the prescaler; the input is
      // sampled on aclk, so it must stay well below half the aclk rate
      count_edge = counter_input && !s.in_q && s.gate_active && !start;

      // ----------------------------------------
      // channel zero
      // ----------------------------------------
      // counts falling edges of the prescaler top bit; the increment trails the
      // wrap by one cycle, long before software reads the result
      next_s.msb_q = start ? 1'b0 : high_nib[3];
      msb_fall     = s.msb_q && !high_nib[3] && !start;
      if (msb_fall) begin
         next_s.high_count = s.high_count + HIGH_W'(1);
         if (s.high_count == HIGH_MAX) begin
            next_s.ovf_out   = 1'b1;
            set_irq.overflow = 1'b1;
         end
      end

      // ----------------------------------------
      // interrupts
      // ----------------------------------------
      // window end raises count-complete while acknowledge enable is high
      if (gate_end && s.ctrl.ack_en) begin
         set_irq.done = 1'b1;
      end

      // dropping acknowledge enable clears both requests; a new event wins
      if (!next_s.ctrl.ack_en) begin
         w1c.done     = 1'b1;
         w1c.overflow = 1'b1;
      end
      next_s.irq_stat.done     = set_irq.done || (s.irq_stat.done && !w1c.done);
      next_s.irq_stat.overflow = set_irq.overflow || (s.irq_stat.overflow && !w1c.overflow);
      next_s.irq_out = |(next_s.irq_stat & next_s.irq_mask);

      // ----------------------------------------
      // register reads
      // ----------------------------------------
      // reads have no side effects; the counts stay until the next start
      next_s.arready = rd_go;
      if (s.rvalid && s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
      if (rd_go) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = RESP_OKAY;
         next_s.rdata  = 32'h0000_0000;
         if (s_axi_araddr == ADDR_CTRL) begin
            next_s.rdata[CTRL_ZSPAN_BIT]       = s.ctrl.zero_span;
            next_s.rdata[CTRL_ACK_BIT]         = s.ctrl.ack_en;
            next_s.rdata[CTRL_RES_LSB +: 3]    = s.ctrl.res;
         end else if (s_axi_araddr == ADDR_STATUS) begin
            next_s.rdata[STATUS_GATE_BIT] = s.gate_active;
            next_s.rdata[STATUS_OVF_BIT]  = s.ovf_out;
         end else if (s_axi_araddr == ADDR_LOW) begin
            next_s.rdata[7:0] = low_count;
         end else if (s_axi_araddr == ADDR_HIGH) begin
            next_s.rdata[HIGH_W-1:0] = s.high_count;
         end else if (s_axi_araddr == ADDR_IRQ_STAT) begin
            next_s.rdata[IRQ_DONE_BIT] = s.irq_stat.done;
            next_s.rdata[IRQ_OVF_BIT]  = s.irq_stat.overflow;
         end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
            next_s.rdata[IRQ_DONE_BIT] = s.irq_mask.done;
            next_s.rdata[IRQ_OVF_BIT]  = s.irq_mask.overflow;
         end else begin
            next_s.rresp = RESP_SLVERR;
         end
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s        <= '0;
         // the gate output idles high, the one field whose reset is not zero
         s.gate_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready        = s.awready;
   assign s_axi_wready         = s.wready;
   assign s_axi_bvalid         = s.bvalid;
   assign s_axi_bresp          = s.bresp;
   assign s_axi_arready        = s.arready;
   assign s_axi_rvalid         = s.rvalid;
   assign s_axi_rresp          = s.rresp;
   assign s_axi_rdata          = s.rdata;
   assign gate_window_out      = s.gate_n;
   assign timer_ch_zero_output = s.ovf_out;
   assign irq                  = s.irq_out;
endmodule

`default_nettype wire

// File: core/if_frequency_counter_end.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// File: core/nibble_counter.sv
`timescale 1ns/10ps
`default_nettype none

module nibble_counter (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // control
   input  wire logic       clear,
   input  wire logic       inc,
   // count
   output logic [3:0]      count,
   output logic            carry
);
   import freq_counter_pkg::*;

   typedef struct packed {
      logic [3:0] count;
   } nib_state_t;

   nib_state_t s;
   nib_state_t next_s;

   always_comb begin
      next_s = s;
      if (clear) begin
         next_s.count = 4'h0;
      end else if (inc) begin
         next_s.count = s.count + 4'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign count = s.count;
   // ripple carry into the next stage when wrapping
   assign carry = inc && !clear && (s.count == NIBBLE_MAX);
endmodule

`default_nettype wire

// File: tb/fc_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module fc_checker
   import freq_counter_pkg::*;
#(
   parameter int GATE_LONG_US_P  = 50,
   parameter int GATE_SHORT_US_P = 5
) (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // measurement outputs
   input wire logic        gate_window_out,
   input wire logic        timer_ch_zero_output,
   input wire logic        irq
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // 100 aclk cycles per microsecond on either timing reference, one microsecond of slack
   localparam int MAX_LOW = GATE_LONG_US_P * 100 + 100;
   localparam int MIN_LOW = GATE_SHORT_US_P * 100 - 100;
   logic       wr_take;
   logic       wr_ctrl;
   logic       start_wr;
   logic       rd_take;
   logic       ack_q;
   logic [1:0] mask_q;
   int         low_cnt;

   assign wr_take  = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid && s_axi_wstrb[0];
   assign wr_ctrl  = wr_take && s_axi_awaddr == ADDR_CTRL;
   assign start_wr = wr_ctrl && s_axi_wdata[CTRL_START_BIT];
   assign rd_take  = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ack_q   <= 1'b0;
         mask_q  <= 2'h0;
         low_cnt <= 0;
      end else begin
         if (wr_ctrl) ack_q <= s_axi_wdata[CTRL_ACK_BIT];
         if (wr_take && s_axi_awaddr == ADDR_IRQ_MASK) mask_q <= s_axi_wdata[1:0];
         low_cnt <= (gate_window_out || start_wr) ? 0 : low_cnt + 1;
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_start;
      start_wr;
   endsequence
   sequence s_read;
      rd_take;
   endsequence

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_GATE_OPENS: assert property (s_start |=> !gate_window_out)
      else $error("gate did not open after start");
   AST_OVF_CLEARED: assert property (s_start |=> !timer_ch_zero_output)
      else $error("overflow output not cleared by start");
   AST_GATE_MAX: assert property (low_cnt <= MAX_LOW)
      else $error("gate open too long");
   AST_GATE_MIN: assert property ($rose(gate_window_out) |-> $past(low_cnt) >= MIN_LOW)
      else $error("gate closed too early");
   AST_DONE_IRQ: assert property ($rose(gate_window_out) && ack_q && mask_q[IRQ_DONE_BIT] |-> ##[0:2] irq)
      else $error("no interrupt at gate close");
   AST_IRQ_MASKED: assert property ((mask_q == 2'h0) [*3] |-> !irq)
      else $error("interrupt with all sources masked");
   AST_WR_ANSWER: assert property (wr_take |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
      else $error("write not answered");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_RD_ANSWER: assert property (s_read |=> s_axi_arready && s_axi_rvalid)
      else $error("read not answered");
   AST_RD_SLVERR: assert property (s_read ##0 s_axi_araddr > ADDR_IRQ_MASK |=> s_axi_rresp == RESP_SLVERR)
      else $error("unmapped read not refused");
endmodule

bind if_frequency_counter fc_checker #(
   .GATE_LONG_US_P(GATE_LONG_US_P), .GATE_SHORT_US_P(GATE_SHORT_US_P)
) i_chk (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .gate_window_out(gate_window_out), .timer_ch_zero_output(timer_ch_zero_output), .irq(irq)
);

`default_nettype wire

// File: tb/if_frequency_counter_tb.sv
`timescale 1ns/10ps
`default_nettype none

module if_frequency_counter_tb;
   import freq_counter_pkg::*;
   localparam int LONG_US  = 50;
   localparam int MID_US   = 20;
   localparam int SHORT_US = 5;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, ref_clk, host_clk, cnt_in;
   logic        gate, ovf, irq, gate_d, cnt_d;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   int          fails, n_checks, glen, edges, keep;

   if_frequency_counter #(
      .GATE_LONG_US_P(LONG_US), .GATE_MID_US_P(MID_US), .GATE_SHORT_US_P(SHORT_US)
   ) i_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ref_clock_in(ref_clk),
      .host_bus_clock(host_clk), .counter_input(cnt_in), .gate_window_out(gate),
      .timer_ch_zero_output(ovf), .irq(irq)
   );
   meas_source i_src (.aclk(aclk), .ref_clock_in(ref_clk), .host_bus_clock(host_clk), .counter_input(cnt_in));

   initial aclk = 1'b0;
   always #5 aclk = ~aclk;

   // gate length and input edges seen while the gate is open
   always @(posedge aclk) begin
      gate_d <= gate;
      cnt_d <= cnt_in;
      if (gate === 1'b0) begin
         glen <= gate_d ? 1 : glen + 1;
         edges <= (gate_d ? 0 : edges) + int'(cnt_in && !cnt_d);
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // start with acknowledge enabled, wait for the interrupt, then read both halves
   task automatic measure(input logic [2:0] res, input logic zs, input int us);
      int n;
      int total;
      wr(ADDR_CTRL, {25'h0, res, 1'b0, 1'b1, zs, 1'b1});
      n = 0;
      while (irq !== 1'b1 && n < 20000) begin
         @(posedge aclk);
         n++;
      end
      check("done irq", irq, 1'b1);
      check("gate length", 32'(glen >= us * 100 - 50 && glen <= us * 100 + 3), 32'h1);
      rd_reg(ADDR_LOW);
      total = int'(rd[7:0]);
      rd_reg(ADDR_HIGH);
      total += int'(rd[15:0]) * 256;
      check("count", 32'(total >= edges - 2 && total <= edges + 2), 32'h1);
      wr(ADDR_IRQ_STAT, 32'h1);
      repeat (3) @(posedge aclk);
      check("irq cleared", irq, 1'b0);
   endtask

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge aclk);
      fails++;
      end_of_test;
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hF;
      fails = 0;
      n_checks = 0;
      glen = 0;
      edges = 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      check("gate idle", gate, 1'b1);
      for (int i = 0; i < 6; i++) begin
         rd_reg(8'(i * 4));
         check("reset value", rd, 32'h0);
      end
      rd_reg(8'h18);
      check("unmapped read", resp, RESP_SLVERR);
      wr(8'h18, 32'h1);
      check("unmapped write", resp, RESP_SLVERR);
      wr(ADDR_LOW, 32'hFF);
      rd_reg(ADDR_LOW);
      check("low read-only", rd, 32'h0);
      // masked completion stays silent until unmasked, acknowledge low clears it
      wr(ADDR_CTRL, 32'h25);
      repeat (700) @(posedge aclk);
      check("masked irq", irq, 1'b0);
      rd_reg(ADDR_IRQ_STAT);
      check("done status", rd, 32'h1);
      wr(ADDR_IRQ_MASK, 32'h1);
      repeat (3) @(posedge aclk);
      check("unmasked irq", irq, 1'b1);
      wr(ADDR_CTRL, 32'h0);
      rd_reg(ADDR_IRQ_STAT);
      check("ack clear", rd, 32'h0);
      for (int r = 0; r < 6; r++) begin
         measure(3'(r), 1'b0, r == 0 ? LONG_US : (r == 1 ? MID_US : SHORT_US));
      end
      measure(3'h2, 1'b1, SHORT_US);
      // closed gate must not count
      rd_reg(ADDR_LOW);
      keep = int'(rd);
      repeat (200) @(posedge aclk);
      rd_reg(ADDR_LOW);
      check("count frozen", rd, 32'(keep));
      check("no overflow", ovf, 1'b0);
      end_of_test;
   end
endmodule

`default_nettype wire

// File: tb/meas_source.sv
`timescale 1ns/10ps
`default_nettype none

module meas_source (
   // clock
   input  wire logic aclk,
   // measurement signals
   output logic      ref_clock_in,
   output logic      host_bus_clock,
   output logic      counter_input
);
   int ph;

   initial begin
      ph = 0;
      ref_clock_in = 1'b0;
      host_bus_clock = 1'b0;
      counter_input = 1'b0;
   end

   // 10 MHz, 4 MHz and 25 MHz levels; the counted signal runs above nominal
   // so that the mid and long gates carry the prescaler into the high count
   always @(posedge aclk) begin
      ph <= (ph + 1) % 100;
      ref_clock_in <= (ph % 10) < 5;
      host_bus_clock <= (ph % 25) < 12;
      counter_input <= (ph % 4) < 2;
   end
endmodule

`default_nettype wire
